// file: src/jtp_pkg.sv
package jtp_pkg;
  localparam int IR_W = 4;
  localparam int DR_W = 32;
  localparam int BSR_W = 8;
  localparam int UID_W = 14;
  localparam int REV_W = 18;
  localparam int SEC_W = 10;
  localparam int SEC_DENY_BIT = 0;
  localparam int SEC_PLL_LOCK_BIT = 4;
  localparam int PLL_RESET_BIT = 30;
  localparam int PLL_BOOT_DBG_BIT = 29;
  localparam logic [DR_W-1:0] PLL_RESET_VAL = 32'h0000_0000;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] INS_EXTEST = 4'h0;
  localparam logic [IR_W-1:0] INS_SAMPLE = 4'h1;
  localparam logic [IR_W-1:0] INS_IDCODE = 4'h2;
  localparam logic [IR_W-1:0] INS_USERCODE = 4'h3;
  localparam logic [IR_W-1:0] INS_CHIP = 4'h4;
  localparam logic [IR_W-1:0] INS_PLL = 4'h8;
  localparam logic [IR_W-1:0] INS_BYPASS = 4'hf;
  localparam int TMS_RESET_CYCLES = 5;
  localparam int PLL_SETTLE_TCKS = 100;

  typedef enum logic [3:0] {
    ST_RESET = 4'h0,
    ST_IDLE = 4'h1,
    ST_SEL_DR = 4'h2,
    ST_CAP_DR = 4'h3,
    ST_SH_DR = 4'h4,
    ST_EX1_DR = 4'h5,
    ST_PA_DR = 4'h6,
    ST_EX2_DR = 4'h7,
    ST_UPD_DR = 4'h8,
    ST_SEL_IR = 4'h9,
    ST_CAP_IR = 4'ha,
    ST_SH_IR = 4'hb,
    ST_EX1_IR = 4'hc,
    ST_PA_IR = 4'hd,
    ST_EX2_IR = 4'he,
    ST_UPD_IR = 4'hf
  } jtp_state_type;
endpackage

// file: src/jtp_sync2.sv
`timescale 1ns/1ps
module jtp_sync2 #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_ce,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_r;
  // first stage feeds only the second stage
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end
endmodule

// file: src/jtp_tap.sv
`timescale 1ns/1ps
// Behaviour
// - one standard test access port at the pins, able to boundary-scan the i/o pins.
// - a 4-bit instruction register and a 32-bit data register shift serially tdi to tdo.
// - an inner chip tap sits behind the port and gives the host code-load and debug reach.
// - five tck cycles with tms high return the test logic to its reset state.
// - the idcode instruction shifts out a 32-bit identity word whose lsb is one.
// - the usercode instruction shifts out the user identifier above a fixed revision.
// - the user identifier comes from fuse user word bits 13..0 and is zero when unfused.
// - the user identifier is loaded by boot code after device reset and is void in reset.
// - with instruction eight the shifted word is written into the pll settings register.
// - fuse bits 13..0 land in usercode bits 31..18.
// - security bit 0 set denies all tap access to the tile state and memory.
// - security bit 4 set refuses pll writes through instruction eight.
module jtp_tap #(
  parameter logic [31:0] IDCODE_VAL = 32'h1234_5679, // arbitrary value, lsb forced to one
  parameter logic [17:0] REVISION_VAL = 18'h0_0001 // arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic [jtp_pkg::UID_W-1:0] i_fused_user_word,
  input wire logic [jtp_pkg::SEC_W-1:0] i_security_config,
  input wire logic i_boot_load,
  input wire logic i_device_in_reset,
  output logic [jtp_pkg::DR_W-1:0] o_pll_settings,
  output logic o_device_reset,
  output logic o_boot_from_debug,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  output logic o_tdo,
  output logic o_tdo_oe,
  output logic o_chip_en,
  output logic o_chip_tms,
  output logic o_chip_tdi,
  input wire logic i_chip_tdo,
  input wire logic [jtp_pkg::BSR_W-1:0] i_pin_in,
  input wire logic [jtp_pkg::BSR_W-1:0] i_core_out,
  output logic [jtp_pkg::BSR_W-1:0] o_pin_out
);
  ////////////////////////////////////////////////////////////////////////////////
  // system clock side
  logic [jtp_pkg::UID_W-1:0] uid_r;
  logic uid_valid_r;
  logic [jtp_pkg::SEC_W-1:0] sec_r;
  logic pll_tog_r, pll_tog_sy, pll_tog_d_r;
  logic pll_pulse;
  logic [jtp_pkg::DR_W-1:0] pll_r;
  logic [jtp_pkg::DR_W-1:0] pll_hold_r;
  logic dev_rst;

  assign dev_rst = i_device_in_reset | pll_r[jtp_pkg::PLL_RESET_BIT];
  assign pll_pulse = pll_tog_d_r ^ pll_tog_sy;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      uid_r <= 14'h0000;
      uid_valid_r <= 1'b0;
    end else if (i_ce) begin
      if (dev_rst) begin
        uid_r <= 14'h0000;
        uid_valid_r <= 1'b0;
      end else if (i_boot_load) begin
        uid_r <= i_fused_user_word;
        uid_valid_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sec_r <= 10'h000;
      pll_tog_d_r <= 1'b0;
      pll_r <= jtp_pkg::PLL_RESET_VAL;
    end else if (i_ce) begin
      sec_r <= i_security_config;
      pll_tog_d_r <= pll_tog_sy;
      // hold word is stable for many tcks after each toggle
      if (pll_pulse) begin
        pll_r <= pll_hold_r;
      end
    end
  end

  jtp_sync2 #(.W(1)) u_pll_sync (
    .i_clk(i_clk),
    .i_ce(i_ce),
    .i_d(pll_tog_r),
    .o_q(pll_tog_sy)
  );

  assign o_pll_settings = pll_r;
  assign o_device_reset = pll_r[jtp_pkg::PLL_RESET_BIT];
  assign o_boot_from_debug = pll_r[jtp_pkg::PLL_BOOT_DBG_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // tck side
  logic t_rstn;
  logic [1:0] sec_t;
  logic uid_ok_t;
  logic [jtp_pkg::BSR_W-1:0] pin_t;
  jtp_pkg::jtp_state_type st_r;
  jtp_pkg::jtp_state_type st_nxt;
  logic [jtp_pkg::IR_W-1:0] ir_r;
  logic [jtp_pkg::IR_W-1:0] irsh_r;
  logic [jtp_pkg::DR_W-1:0] dr_r;
  logic [jtp_pkg::BSR_W-1:0] bsr_r;
  logic [jtp_pkg::BSR_W-1:0] bsr_upd_r;
  logic byp_r;
  logic tdo_r;
  logic tdo_oe_r;
  logic deny;
  logic pll_lock;
  logic sel_bsr;
  logic sel_dr32;
  logic sel_chip;
  logic tdo_nxt;

  jtp_sync2 #(.W(1)) u_rst_sync (
    .i_clk(i_tck),
    .i_ce(1'b1),
    .i_d(i_resetn),
    .o_q(t_rstn)
  );

  jtp_sync2 #(.W(3)) u_sec_sync (
    .i_clk(i_tck),
    .i_ce(1'b1),
    .i_d({sec_r[jtp_pkg::SEC_DENY_BIT], sec_r[jtp_pkg::SEC_PLL_LOCK_BIT], uid_valid_r}),
    .o_q({sec_t, uid_ok_t})
  );

  // pins are asynchronous to tck, so boundary capture reads synchronised copies
  jtp_sync2 #(.W(jtp_pkg::BSR_W)) u_pin_sync (
    .i_clk(i_tck),
    .i_ce(1'b1),
    .i_d(i_pin_in),
    .o_q(pin_t)
  );

  assign deny = sec_t[1];
  assign pll_lock = sec_t[0];

  function automatic jtp_pkg::jtp_state_type next_state(input jtp_pkg::jtp_state_type s,
                                                       input logic tms);
    case (s)
      jtp_pkg::ST_RESET: next_state = tms ? jtp_pkg::ST_RESET : jtp_pkg::ST_IDLE;
      jtp_pkg::ST_IDLE: next_state = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
      jtp_pkg::ST_SEL_DR: next_state = tms ? jtp_pkg::ST_SEL_IR : jtp_pkg::ST_CAP_DR;
      jtp_pkg::ST_CAP_DR: next_state = tms ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SH_DR;
      jtp_pkg::ST_SH_DR: next_state = tms ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SH_DR;
      jtp_pkg::ST_EX1_DR: next_state = tms ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_PA_DR;
      jtp_pkg::ST_PA_DR: next_state = tms ? jtp_pkg::ST_EX2_DR : jtp_pkg::ST_PA_DR;
      jtp_pkg::ST_EX2_DR: next_state = tms ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_SH_DR;
      jtp_pkg::ST_UPD_DR: next_state = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
      jtp_pkg::ST_SEL_IR: next_state = tms ? jtp_pkg::ST_RESET : jtp_pkg::ST_CAP_IR;
      jtp_pkg::ST_CAP_IR: next_state = tms ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SH_IR;
      jtp_pkg::ST_SH_IR: next_state = tms ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SH_IR;
      jtp_pkg::ST_EX1_IR: next_state = tms ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_PA_IR;
      jtp_pkg::ST_PA_IR: next_state = tms ? jtp_pkg::ST_EX2_IR : jtp_pkg::ST_PA_IR;
      jtp_pkg::ST_EX2_IR: next_state = tms ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_SH_IR;
      jtp_pkg::ST_UPD_IR: next_state = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
      default: next_state = jtp_pkg::ST_RESET;
    endcase
  endfunction

  assign st_nxt = next_state(st_r, i_tms);
  assign sel_bsr = (ir_r == jtp_pkg::INS_EXTEST) || (ir_r == jtp_pkg::INS_SAMPLE);
  assign sel_dr32 = (ir_r == jtp_pkg::INS_IDCODE) || (ir_r == jtp_pkg::INS_USERCODE)
                    || (ir_r == jtp_pkg::INS_PLL);
  assign sel_chip = (ir_r == jtp_pkg::INS_CHIP) && !deny;

  always_ff @(posedge i_tck) begin
    if (!t_rstn) begin
      st_r <= jtp_pkg::ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge i_tck) begin
    if (!t_rstn || st_r == jtp_pkg::ST_RESET) begin
      ir_r <= jtp_pkg::INS_IDCODE;
      irsh_r <= 4'h0;
    end else if (st_r == jtp_pkg::ST_CAP_IR) begin
      irsh_r <= jtp_pkg::IR_CAPTURE;
    end else if (st_r == jtp_pkg::ST_SH_IR) begin
      irsh_r <= {i_tdi, irsh_r[3:1]};
    end else if (st_r == jtp_pkg::ST_UPD_IR) begin
      ir_r <= irsh_r;
    end
  end

  always_ff @(posedge i_tck) begin
    if (!t_rstn) begin
      dr_r <= 32'h0000_0000;
      byp_r <= 1'b0;
      bsr_r <= 8'h00;
    end else if (st_r == jtp_pkg::ST_CAP_DR) begin
      byp_r <= 1'b0;
      bsr_r <= pin_t;
      if (ir_r == jtp_pkg::INS_IDCODE) begin
        dr_r <= {IDCODE_VAL[31:1], 1'b1};
      end else if (ir_r == jtp_pkg::INS_USERCODE) begin
        dr_r <= {(uid_ok_t ? uid_r : 14'h0000), REVISION_VAL};
      end
    end else if (st_r == jtp_pkg::ST_SH_DR) begin
      byp_r <= i_tdi;
      if (sel_bsr) begin
        bsr_r <= {i_tdi, bsr_r[7:1]};
      end
      if (sel_dr32) begin
        dr_r <= {i_tdi, dr_r[31:1]};
      end
    end
  end

  // hold word and toggle stay put until the next write; the system side samples late
  always_ff @(posedge i_tck) begin
    if (!t_rstn) begin
      pll_hold_r <= jtp_pkg::PLL_RESET_VAL;
      pll_tog_r <= 1'b0;
      bsr_upd_r <= 8'h00;
    end else if (st_r == jtp_pkg::ST_UPD_DR) begin
      if (ir_r == jtp_pkg::INS_PLL && !pll_lock) begin
        pll_hold_r <= dr_r;
        pll_tog_r <= ~pll_tog_r;
      end
      if (ir_r == jtp_pkg::INS_EXTEST) begin
        bsr_upd_r <= bsr_r;
      end
    end
  end

  assign o_pin_out = (ir_r == jtp_pkg::INS_EXTEST) ? bsr_upd_r : i_core_out;

  // inner tap parks in its reset state while not selected
  assign o_chip_en = sel_chip;
  assign o_chip_tms = sel_chip ? i_tms : 1'b1;
  assign o_chip_tdi = sel_chip ? i_tdi : 1'b0;

  assign tdo_nxt = (st_r == jtp_pkg::ST_SH_IR) ? irsh_r[0] :
                   sel_bsr ? bsr_r[0] :
                   sel_dr32 ? dr_r[0] :
                   sel_chip ? i_chip_tdo : byp_r;

  // tdo changes on the falling edge so the host samples a settled bit
  always_ff @(negedge i_tck) begin
    if (!t_rstn) begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else begin
      tdo_r <= tdo_nxt;
      tdo_oe_r <= (st_r == jtp_pkg::ST_SH_IR) || (st_r == jtp_pkg::ST_SH_DR);
    end
  end
  assign o_tdo = tdo_r;
  assign o_tdo_oe = tdo_oe_r;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_pll_shot;
    st_r == jtp_pkg::ST_UPD_DR && ir_r == jtp_pkg::INS_PLL;
  endsequence

  tms_five_reset_a: assert property (@(posedge i_tck) disable iff (!t_rstn)
    i_tms [*5] |=> st_r == jtp_pkg::ST_RESET)
    else $error("five tms highs did not reset the tap");
  idcode_lsb_a: assert property (@(posedge i_tck) disable iff (!t_rstn)
    st_r == jtp_pkg::ST_CAP_DR && ir_r == jtp_pkg::INS_IDCODE
    |=> dr_r[0] && dr_r[1] == IDCODE_VAL[1])
    else $error("idcode capture wrong");
  usercode_map_a: assert property (@(posedge i_tck) disable iff (!t_rstn)
    st_r == jtp_pkg::ST_CAP_DR && ir_r == jtp_pkg::INS_USERCODE && !uid_ok_t
    |=> dr_r == {14'h0000, REVISION_VAL})
    else $error("usercode not zero with revision");
  pll_write_a: assert property (@(posedge i_tck) disable iff (!t_rstn)
    s_pll_shot ##0 !pll_lock |=> pll_tog_r != $past(pll_tog_r) && pll_hold_r == $past(dr_r))
    else $error("pll write not launched");
  pll_lock_a: assert property (@(posedge i_tck) disable iff (!t_rstn)
    s_pll_shot ##0 pll_lock |=> $stable(pll_tog_r))
    else $error("locked pll write launched");
  ir_shift_a: assert property (@(posedge i_tck) disable iff (!t_rstn)
    st_r == jtp_pkg::ST_SH_IR |=> irsh_r[3] == $past(i_tdi) && irsh_r[2:0] == $past(irsh_r[3:1]))
    else $error("ir shift wrong");
  chip_deny_a: assert property (@(posedge i_tck) disable iff (!t_rstn)
    deny |-> !o_chip_en && o_chip_tms)
    else $error("chip tap reachable while denied");
  pll_land_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    pll_pulse && i_ce |=> o_pll_settings == $past(pll_hold_r))
    else $error("pll settings not written");
  uid_reset_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    dev_rst && i_ce |=> uid_r == 14'h0000 && !uid_valid_r)
    else $error("user identifier kept during device reset");
endmodule

// file: sim/jtp_host.sv
`timescale 1ns/1ps
module jtp_host (
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  input wire logic i_tdo
);
  // tck stands low between frames; tdi flips there so a stale bit never reads as data
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #40;
    tdo = i_tdo;
    o_tck = 1'b1;
    #80;
    o_tck = 1'b0;
    #40;
  endtask
  task automatic park();
    o_tdi = ~o_tdi;
  endtask
  task automatic tms_reset(input int n);
    logic d;
    repeat (n) step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
    park();
  endtask
  task automatic idle(input int n);
    logic d;
    repeat (n) step(1'b0, 1'b0, d);
    park();
  endtask
  // walk from idle to a shift state and back, lsb first
  task automatic scan(input logic is_ir, input logic [31:0] din, input int n,
                      output logic [31:0] dout);
    logic d;
    dout = '0;
    step(1'b1, 1'b0, d);
    if (is_ir) step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
    step(1'b0, 1'b0, d);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], d);
      dout[i] = d;
    end
    step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
    park();
  endtask
endmodule

// file: sim/jtag_tap_with_pll_access_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %0t: got %h exp %h", $time, (g), (e)); end end
module jtag_tap_with_pll_access_tb_top;
  localparam logic [31:0] ID_V = 32'h1234_5679; // arbitrary value
  localparam logic [17:0] REV_V = 18'h0_0001; // arbitrary value
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [jtp_pkg::UID_W-1:0] fuse = '0;
  logic [jtp_pkg::SEC_W-1:0] sec = '0;
  logic boot = 1'b0, dev_rst = 1'b0, chip_tdo = 1'b0, ce = 1'b1;
  logic [7:0] pin_in = '0, core_out = '0, pin_out;
  logic [31:0] pll, cap, r;
  logic dres, bdbg, tck, tms, tdi, tdo, tdo_oe, chip_en, chip_tms, chip_tdi;
  int num_errors = 0, tests_run = 0, seed = 32'h63911ac2, uid_m = 0, pll_m = 0;

  jtp_tap #(.IDCODE_VAL(ID_V), .REVISION_VAL(REV_V)) jtp_tap_i (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(ce), .i_fused_user_word(fuse),
    .i_security_config(sec), .i_boot_load(boot), .i_device_in_reset(dev_rst),
    .o_pll_settings(pll), .o_device_reset(dres), .o_boot_from_debug(bdbg),
    .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe),
    .o_chip_en(chip_en), .o_chip_tms(chip_tms), .o_chip_tdi(chip_tdi),
    .i_chip_tdo(chip_tdo), .i_pin_in(pin_in), .i_core_out(core_out), .o_pin_out(pin_out));
  jtp_host jtp_host_i (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo));

  always #10 i_clk = ~i_clk;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] exp_dr(input logic [3:0] ir);
    case (ir)
      jtp_pkg::INS_IDCODE: return {ID_V[31:1], 1'b1};
      jtp_pkg::INS_USERCODE: return {uid_m[13:0], REV_V};
      default: return 32'h0;
    endcase
  endfunction
  task automatic sys_tick();
    @(posedge i_clk);
    #1;
  endtask
  task automatic set_ir(input logic [3:0] c);
    jtp_host_i.scan(1'b1, {28'h0, c}, 4, cap);
    `CHK(cap[3:0], jtp_pkg::IR_CAPTURE)
  endtask
  task automatic read_cur(input logic [3:0] c);
    // a drive enable that never rises hangs here, and the watchdog fails the run
    fork
      jtp_host_i.scan(1'b0, 32'h0, 32, cap);
      @(posedge tdo_oe);
    join
    `CHK(cap, exp_dr(c))
    `CHK(tdo_oe, 1'b0)
  endtask
  task automatic read_dr(input logic [3:0] c);
    set_ir(c);
    read_cur(c);
  endtask
  task automatic boot_pulse();
    sys_tick();
    boot = 1'b1;
    sys_tick();
    boot = 1'b0;
  endtask
  task automatic pll_write(input logic [31:0] d);
    set_ir(jtp_pkg::INS_PLL);
    jtp_host_i.scan(1'b0, d, 32, cap);
    jtp_host_i.idle(jtp_pkg::PLL_SETTLE_TCKS);
    if (!sec[jtp_pkg::SEC_PLL_LOCK_BIT]) pll_m = d;
    if (pll_m[30]) uid_m = 0;
    `CHK(pll, pll_m[31:0])
    `CHK({dres, bdbg}, {pll_m[30], pll_m[29]})
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    // tck side takes reset through a sync, so tck runs while reset is held
    fork
      repeat (12) @(posedge i_clk);
      jtp_host_i.tms_reset(8);
    join
    sys_tick();
    i_resetn = 1'b1;
    jtp_host_i.tms_reset(5);
    read_cur(jtp_pkg::INS_IDCODE);
    read_dr(jtp_pkg::INS_USERCODE);
    $display("test reset_id done");
    sys_tick();
    fuse = jtp_pkg::UID_W'($random(seed));
    dev_rst = 1'b1;
    boot_pulse();
    sys_tick();
    dev_rst = 1'b0;
    read_dr(jtp_pkg::INS_USERCODE);
    boot_pulse();
    uid_m = int'(fuse);
    jtp_host_i.idle(4);
    read_dr(jtp_pkg::INS_USERCODE);
    $display("test usercode done");
    r = $random(seed);
    r[30] = 1'b0;
    pll_write(r);
    pll_write(r | 32'h4000_0000);
    read_dr(jtp_pkg::INS_USERCODE);
    pll_write(32'h0);
    sys_tick();
    sec = 10'h010;
    pll_write(~r);
    sys_tick();
    sec = '0;
    sys_tick();
    // a frozen system side must not take the write until the enable returns
    ce = 1'b0;
    jtp_host_i.scan(1'b0, r, 32, cap);
    jtp_host_i.idle(jtp_pkg::PLL_SETTLE_TCKS);
    `CHK(pll, pll_m[31:0])
    sys_tick();
    ce = 1'b1;
    pll_m = r;
    jtp_host_i.idle(4);
    `CHK(pll, pll_m[31:0])
    $display("test pll done");
    set_ir(jtp_pkg::INS_CHIP);
    #1;
    `CHK({chip_en, chip_tms, chip_tdi}, {1'b1, 1'b0, tdi})
    chip_tdo = 1'b1;
    jtp_host_i.scan(1'b0, 32'h0, 2, cap);
    `CHK(cap[1:0], 2'b11)
    sys_tick();
    sec = 10'h001;
    // the security word reaches the tck side through its sync, so tck must run
    jtp_host_i.idle(4);
    `CHK({chip_en, chip_tms, chip_tdi}, 3'b010)
    jtp_host_i.scan(1'b0, 32'h3, 2, cap);
    `CHK(cap[1:0], 2'b10)
    for (int c = 5; c < 8; c++) begin
      set_ir(4'(c));
      jtp_host_i.scan(1'b0, 32'h3, 2, cap);
      `CHK(cap[1:0], 2'b10)
    end
    sys_tick();
    sec = '0;
    jtp_host_i.tms_reset(5);
    read_cur(jtp_pkg::INS_IDCODE);
    $display("test chip_bypass done");
    sys_tick();
    pin_in = 8'($random(seed));
    core_out = 8'($random(seed));
    chip_tdo = 1'b1;
    set_ir(jtp_pkg::INS_SAMPLE);
    jtp_host_i.scan(1'b0, 32'h0, 8, cap);
    `CHK(cap[7:0], pin_in)
    `CHK(pin_out, core_out)
    set_ir(jtp_pkg::INS_EXTEST);
    r = $random(seed);
    jtp_host_i.scan(1'b0, r, 8, cap);
    `CHK(cap[7:0], pin_in)
    `CHK(pin_out, r[7:0])
    $display("test boundary done");
    test_done();
  end
  initial begin
    #1_000_000;
    num_errors++;
    test_done();
  end
endmodule
